// file: src/link_pkg.sv
// Constants, register map and decoding helpers of the serial slave link.
// Assumes a 10 MHz system clock; all cycle counts below derive from CLK_HZ.
package link_pkg;

    localparam int          CLK_HZ         = 10_000_000;
    localparam int          SEC_S          = 1;
    localparam int          SEC_CYCLES     = SEC_S * CLK_HZ;

    // Register byte offsets
    localparam logic [7:0]  OFS_STATION    = 8'h00;
    localparam logic [7:0]  OFS_BAUD       = 8'h04;
    localparam logic [7:0]  OFS_CTRL       = 8'h08;
    localparam logic [7:0]  OFS_TIMEOUT    = 8'h0c;
    localparam logic [7:0]  OFS_REPLY      = 8'h10;
    localparam logic [7:0]  OFS_STATUS     = 8'h14;

    // Values after reset
    localparam logic [7:0]  RST_STATION    = 8'h01;
    localparam logic [2:0]  RST_BAUD       = 3'h3;
    localparam logic        RST_WR_EN      = 1'b0;
    localparam logic [6:0]  RST_TIMEOUT    = 7'h00;
    localparam logic [2:0]  RST_REPLY      = 3'h0;

    // Field limits and codes
    localparam logic [7:0]  STATION_MAX    = 8'hc7;
    localparam logic [7:0]  BROADCAST_ADDR = 8'hff;
    localparam logic [6:0]  TIMEOUT_MAX    = 7'h63;
    localparam logic [2:0]  REPLY_SEL_MAX  = 3'h5;
    localparam logic [15:0] OPEN_REG_A     = 16'h0004;
    localparam logic [15:0] OPEN_REG_B     = 16'h0005;

    // Character framing in bit times
    localparam int          CHAR_BITS      = 11;
    localparam logic [5:0]  FRAME_GAP_BITS = 6'h27;
    localparam logic [3:0]  TX_FRAME_BITS  = 4'ha;
    localparam logic [3:0]  RX_DATA_BITS   = 4'h8;
    localparam int          DIV_W          = 14;

    function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
        unique case (sel)
            3'h0: baud_div = DIV_W'(CLK_HZ / 1200);
            3'h1: baud_div = DIV_W'(CLK_HZ / 2400);
            3'h2: baud_div = DIV_W'(CLK_HZ / 4800);
            3'h3: baud_div = DIV_W'(CLK_HZ / 9600);
            3'h4: baud_div = DIV_W'(CLK_HZ / 19200);
            3'h5: baud_div = DIV_W'(CLK_HZ / 38400);
            3'h6: baud_div = DIV_W'(CLK_HZ / 57600);
            3'h7: baud_div = DIV_W'(CLK_HZ / 115200);
        endcase
    endfunction : baud_div

    // Reply delay in bit times; code 0 is the standard, undelayed answer
    function automatic logic [11:0] reply_bits(input logic [2:0] sel);
        case (sel)
            3'h1:    reply_bits = 12'(10 * CHAR_BITS);
            3'h2:    reply_bits = 12'(20 * CHAR_BITS);
            3'h3:    reply_bits = 12'(50 * CHAR_BITS);
            3'h4:    reply_bits = 12'(100 * CHAR_BITS);
            3'h5:    reply_bits = 12'(200 * CHAR_BITS);
            default: reply_bits = 12'h000;
        endcase
    endfunction : reply_bits

endpackage : link_pkg

// file: src/modbus_serial_slave_link.sv
// Serial slave link: RS-485 byte receiver and transmitter with station match,
// access gate for configuration writes, frame gap supervision and reply delay.
// Assumes rxd is synchronous to clk_sys and one AHB-Lite master with hready.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module modbus_serial_slave_link
    import link_pkg::*;
#(
    parameter int SEC_CYCLES_P = SEC_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // RS-485 pins
    input  wire logic        rxd,
    output logic             txd,
    output logic             tx_drive_en,
    // Received bytes of frames for this station
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    output logic             rx_frame_end,
    // Reply bytes
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    // Configuration write gate for the protocol engine
    input  wire logic        cfg_wr_req,
    input  wire logic [15:0] cfg_wr_reg,
    output logic             cfg_wr_allow,
    // Alert relay driven by the frame gap supervision
    output logic             relay_alert
);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

    // Configuration
    logic [7:0]       station_q;
    logic [2:0]       baud_q;
    logic             wr_en_q;
    logic [6:0]       timeout_q;
    logic [2:0]       reply_q;
    // Bus pipeline
    logic             ph_wr_q;
    logic [7:0]       ph_ofs_q;
    logic [31:0]      hrdata_q;
    // Bit tick and receiver
    logic [DIV_W-1:0] tick_cnt_q;
    rx_state_t        rx_st_q;
    logic [DIV_W-1:0] rx_cnt_q;
    logic [3:0]       rx_bit_q;
    logic [7:0]       rx_sh_q;
    logic [7:0]       rx_data_q;
    logic             rx_valid_q;
    // Frame tracking
    logic             in_frame_q;
    logic             first_q;
    logic             mine_q;
    logic             bad_q;
    logic [5:0]       gap_bits_q;
    logic             frame_end_q;
    // Supervision and reply
    logic [31:0]      sec_cnt_q;
    logic [6:0]       gap_s_q;
    logic             alert_q;
    logic [11:0]      dly_q;
    logic             dly_run_q;
    logic             open_q;
    // Transmitter
    logic             tx_busy_q;
    logic [9:0]       tx_sh_q;
    logic [3:0]       tx_bit_q;
    logic [DIV_W-1:0] tx_cnt_q;
    logic             txd_q;

    // Decode
    wire logic [DIV_W-1:0] div      = baud_div(baud_q);
    wire logic             bit_tick = (tick_cnt_q == '0);
    wire logic             ahb_take = hsel & hready & htrans[1];
    wire logic             wr_now   = ph_wr_q;
    wire logic [7:0]       a_ofs    = haddr[7:0];
    wire logic             rx_fall  = (rx_st_q == RX_IDLE) & ~rxd;
    wire logic             rx_samp  = (rx_st_q != RX_IDLE) & (rx_cnt_q == '0);
    wire logic             byte_ok  = rx_samp & (rx_st_q == RX_STOP) & rxd;
    wire logic             byte_bad = rx_samp & (rx_st_q == RX_STOP) & ~rxd;
    wire logic             frame_done = in_frame_q & (rx_st_q == RX_IDLE) & bit_tick
                                        & (gap_bits_q == FRAME_GAP_BITS - 6'h01);
    wire logic             addr_hit = (station_q == 8'h00) ?
                                      (rx_sh_q == BROADCAST_ADDR) :
                                      (rx_sh_q == station_q);
    wire logic             sec_tick = (sec_cnt_q == 32'(SEC_CYCLES_P - 1));
    wire logic             tx_take  = tx_valid & tx_ready;
    wire logic             tx_step  = tx_busy_q & (tx_cnt_q == '0);

    wire logic [31:0] rd_word =
        (a_ofs == OFS_STATION) ? {24'h000000, station_q} :
        (a_ofs == OFS_BAUD)    ? {29'h00000000, baud_q} :
        (a_ofs == OFS_CTRL)    ? {31'h00000000, wr_en_q} :
        (a_ofs == OFS_TIMEOUT) ? {25'h0000000, timeout_q} :
        (a_ofs == OFS_REPLY)   ? {29'h00000000, reply_q} :
        (a_ofs == OFS_STATUS)  ? {28'h0000000, tx_busy_q, open_q, in_frame_q, alert_q} :
                                 32'h00000000;

    // AHB-Lite: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ph_wr_q  <= 1'b0;
            ph_ofs_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else if (clk_en) begin
            if (hready) begin
                ph_wr_q  <= ahb_take & hwrite;
                ph_ofs_q <= a_ofs;
            end
            if (ahb_take & ~hwrite) begin
                hrdata_q <= rd_word;
            end
        end
    end

    // Out-of-range station, timeout and reply writes leave the old value, so the fields never leave their limits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            station_q <= RST_STATION;
            baud_q    <= RST_BAUD;
            wr_en_q   <= RST_WR_EN;
            timeout_q <= RST_TIMEOUT;
            reply_q   <= RST_REPLY;
        end else if (clk_en && wr_now) begin
            if (ph_ofs_q == OFS_STATION && hwdata[31:8] == '0
                && hwdata[7:0] <= STATION_MAX) begin
                station_q <= hwdata[7:0];
            end
            if (ph_ofs_q == OFS_BAUD) begin
                baud_q <= hwdata[2:0];
            end
            if (ph_ofs_q == OFS_CTRL) begin
                wr_en_q <= hwdata[0];
            end
            if (ph_ofs_q == OFS_TIMEOUT && hwdata[31:7] == '0
                && hwdata[6:0] <= TIMEOUT_MAX) begin
                timeout_q <= hwdata[6:0];
            end
            if (ph_ofs_q == OFS_REPLY && hwdata[31:3] == '0
                && hwdata[2:0] <= REPLY_SEL_MAX) begin
                reply_q <= hwdata[2:0];
            end
        end
    end

    // Link write gate: two registers bypass the access switch
    assign cfg_wr_allow = cfg_wr_req & (wr_en_q
                          | cfg_wr_reg == OPEN_REG_A
                          | cfg_wr_reg == OPEN_REG_B);

    // Free-running bit-time tick for gap and reply counting
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tick_cnt_q <= '0;
        end else if (clk_en) begin
            tick_cnt_q <= bit_tick ? div - 1'b1 : tick_cnt_q - 1'b1;
        end
    end

    // Receiver, 8N1, sampled at mid-bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_st_q  <= RX_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= 4'h0;
            rx_sh_q  <= 8'h00;
        end else if (clk_en) begin
            if (rx_fall) begin
                rx_st_q  <= RX_START;
                rx_cnt_q <= div >> 1;
            end else if (rx_st_q != RX_IDLE) begin
                rx_cnt_q <= rx_samp ? div - 1'b1 : rx_cnt_q - 1'b1;
                if (rx_samp) begin
                    unique case (rx_st_q)
                        RX_START: begin
                            rx_st_q  <= rxd ? RX_IDLE : RX_DATA;
                            rx_bit_q <= 4'h0;
                        end
                        RX_DATA: begin
                            rx_sh_q  <= {rxd, rx_sh_q[7:1]};
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == RX_DATA_BITS - 4'h1) begin
                                rx_st_q <= RX_STOP;
                            end
                        end
                        RX_STOP: rx_st_q <= RX_IDLE;
                        RX_IDLE: rx_st_q <= RX_IDLE;
                    endcase
                end
            end
        end
    end

    // Frame tracking: a frame ends after 3.5 character times of silence
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            in_frame_q  <= 1'b0;
            first_q     <= 1'b1;
            mine_q      <= 1'b0;
            bad_q       <= 1'b0;
            gap_bits_q  <= 6'h00;
            frame_end_q <= 1'b0;
            rx_data_q   <= 8'h00;
            rx_valid_q  <= 1'b0;
        end else if (clk_en) begin
            frame_end_q <= frame_done & mine_q & ~bad_q;
            rx_valid_q  <= 1'b0;
            if (rx_st_q != RX_IDLE || rx_fall) begin
                gap_bits_q <= 6'h00;
            end else if (in_frame_q && bit_tick) begin
                gap_bits_q <= gap_bits_q + 6'h01;
            end
            if (byte_ok || byte_bad) begin
                in_frame_q <= 1'b1;
                first_q    <= 1'b0;
                bad_q      <= bad_q | byte_bad;
                if (first_q) begin
                    mine_q <= byte_ok & addr_hit;
                end
                if (byte_ok && (first_q ? addr_hit : mine_q)) begin
                    rx_data_q  <= rx_sh_q;
                    rx_valid_q <= 1'b1;
                end
            end else if (frame_done) begin
                in_frame_q <= 1'b0;
                first_q    <= 1'b1;
                mine_q     <= 1'b0;
                bad_q      <= 1'b0;
            end
        end
    end

    assign rx_data      = rx_data_q;
    assign rx_valid     = rx_valid_q;
    assign rx_frame_end = frame_end_q;

    // Frame gap supervision in whole seconds
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sec_cnt_q <= 32'h00000000;
            gap_s_q   <= 7'h00;
            alert_q   <= 1'b0;
        end else if (clk_en) begin
            if (frame_end_q) begin
                sec_cnt_q <= 32'h00000000;
                gap_s_q   <= 7'h00;
                alert_q   <= 1'b0;
            end else begin
                sec_cnt_q <= sec_tick ? 32'h00000000 : sec_cnt_q + 32'h00000001;
                if (sec_tick && gap_s_q != 7'h7f) begin
                    gap_s_q <= gap_s_q + 7'h01;
                end
                if (timeout_q == 7'h00) begin
                    alert_q <= 1'b0;
                end else if (gap_s_q > timeout_q) begin
                    alert_q <= 1'b1;
                end
            end
        end
    end

    assign relay_alert = alert_q;

    // Reply window: opens after the selected delay, closes when the master talks again
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dly_q     <= 12'h000;
            dly_run_q <= 1'b0;
            open_q    <= 1'b0;
        end else if (clk_en) begin
            if (frame_end_q) begin
                dly_q     <= reply_bits(reply_q);
                dly_run_q <= 1'b1;
                open_q    <= 1'b0;
            end else if (dly_run_q) begin
                if (dly_q == 12'h000) begin
                    dly_run_q <= 1'b0;
                    open_q    <= 1'b1;
                end else if (bit_tick) begin
                    dly_q <= dly_q - 12'h001;
                end
            end else if (rx_fall) begin
                open_q <= 1'b0;
            end
        end
    end

    // Transmitter, 8N1, LSB first
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= 10'h3ff;
            tx_bit_q  <= 4'h0;
            tx_cnt_q  <= '0;
            txd_q     <= 1'b1;
        end else if (clk_en) begin
            if (tx_take) begin
                tx_busy_q <= 1'b1;
                tx_sh_q   <= {1'b1, tx_data, 1'b0};
                tx_bit_q  <= 4'h0;
                tx_cnt_q  <= div - 1'b1;
                txd_q     <= 1'b0;
            end else if (tx_step) begin
                tx_cnt_q <= div - 1'b1;
                tx_bit_q <= tx_bit_q + 4'h1;
                tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
                txd_q    <= tx_sh_q[1];
                if (tx_bit_q == TX_FRAME_BITS - 4'h1) begin
                    tx_busy_q <= 1'b0;
                    txd_q     <= 1'b1;
                end
            end else if (tx_busy_q) begin
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end
        end
    end

    assign tx_ready    = open_q & ~tx_busy_q & clk_en;
    assign txd         = txd_q;
    assign tx_drive_en = tx_busy_q;

endmodule : modbus_serial_slave_link

// file: verification/link_props.sv
// Port checker of the serial slave link.
// Assumes one clock domain; the bench binds it to the top module.
`timescale 1ns/1ps
module link_props
    import link_pkg::*;
#(
    parameter int SEC_CYCLES_P = SEC_CYCLES
) (
    // Clock, reset, enable
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    // Bus answer
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Serial line and byte streams
    input wire logic        txd,
    input wire logic        tx_drive_en,
    input wire logic        rx_valid,
    input wire logic        rx_frame_end,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    // Write gate and relay
    input wire logic        cfg_wr_req,
    input wire logic [15:0] cfg_wr_reg,
    input wire logic        cfg_wr_allow,
    input wire logic        relay_alert
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_hready; hreadyout; endproperty
    a_hready: assert property (p_hready) else $error("bus slave inserted a wait");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus slave gave an error");
    property p_gate_req; cfg_wr_allow |-> cfg_wr_req; endproperty
    a_gate_req: assert property (p_gate_req) else $error("write allowed unasked");
    property p_open_regs;
        cfg_wr_req && (cfg_wr_reg == OPEN_REG_A || cfg_wr_reg == OPEN_REG_B) |-> cfg_wr_allow;
    endproperty
    a_open_regs: assert property (p_open_regs) else $error("open register refused");
    property p_tx_start; clk_en && tx_valid && tx_ready |=> !txd && tx_drive_en; endproperty
    a_tx_start: assert property (p_tx_start) else $error("reply not started");
    property p_tx_hold; $rose(tx_drive_en) |-> tx_drive_en [*8]; endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("driver enable too short");
    property p_idle_line; !tx_drive_en |-> txd; endproperty
    a_idle_line: assert property (p_idle_line) else $error("line not idle high");
    property p_ready_idle; tx_ready |-> !tx_drive_en; endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready while sending");
    property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("byte strobe too long");
    property p_alert_clear; clk_en && rx_frame_end |=> !relay_alert; endproperty
    a_alert_clear: assert property (p_alert_clear) else $error("alert kept");

    c_frame: cover property (rx_frame_end);
    c_alert: cover property ($rose(relay_alert));
    c_reply: cover property (tx_valid && tx_ready);
endmodule : link_props

// file: verification/modbus_master_model.sv
// Behavioural bus master on the RS-485 pair: sends 8N1 bytes, reads replies.
// Assumes the bench sets div to the cycles of one bit at the chosen rate.
`timescale 1ns/1ps
module modbus_master_model (
    // Clock
    input wire logic clk_sys,
    // Line
    output logic     rxd,
    input wire logic txd,
    input wire logic tx_drive_en
);
    int div = 1041;

    // Biased pair rests high between characters
    initial rxd = 1'b1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= sh[i];
            repeat (div) @(posedge clk_sys);
        end
    endtask : send_byte

    task automatic get_byte(output logic [7:0] b, output logic stop);
        while (txd !== 1'b0) @(posedge clk_sys);
        repeat (div / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk_sys);
            b[i] = txd;
        end
        repeat (div) @(posedge clk_sys);
        stop = txd;
    endtask : get_byte
endmodule : modbus_master_model

// file: verification/tb.sv
// Self-checking bench of the serial slave link: AHB-Lite register access,
// write gate, station match, reply delay and frame gap supervision.
`timescale 1ns/1ps
module tb
    import link_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        sys_rst, clk_en, hsel, hwrite, rxd, txd, tx_drive_en;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire logic   hready;
    logic        hreadyout, hresp, rx_valid, rx_frame_end, tx_valid, tx_ready;
    logic [7:0]  rx_data, tx_data, rb;
    logic        cfg_wr_req, cfg_wr_allow, relay_alert, stop, got_end;
    logic [15:0] cfg_wr_reg;
    logic [31:0] d;
    logic [7:0]  rxq[$];
    int          bad_count = 0;
    int          compares = 0;
    int          div;

    always #50 clk_sys = ~clk_sys;
    assign hready = hreadyout;

    modbus_serial_slave_link #(.SEC_CYCLES_P(200)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
        .tx_drive_en(tx_drive_en), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_frame_end(rx_frame_end), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .cfg_wr_req(cfg_wr_req), .cfg_wr_reg(cfg_wr_reg),
        .cfg_wr_allow(cfg_wr_allow), .relay_alert(relay_alert));

    modbus_master_model master (
        .clk_sys(clk_sys), .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en));

    always @(posedge clk_sys) begin
        if (rx_valid === 1'b1) begin
            rxq.push_back(rx_data);
        end
    end

    task automatic finish_test();
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    // Address phase held until hready, then data phase held until hready
    task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                            output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ahb_xfer(a, 1'b1, v, d);
    endtask : wr

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        ahb_xfer(a, 1'b0, 32'h00000000, d);
        check(d, exp, "register readback");
    endtask : chk_reg

    task automatic gate(input logic [15:0] r, input logic exp);
        cfg_wr_req <= 1'b1;
        cfg_wr_reg <= r;
        @(posedge clk_sys);
        check({31'h0, cfg_wr_allow}, {31'h0, exp}, "write gate");
        cfg_wr_req <= 1'b0;
        @(posedge clk_sys);
    endtask : gate

    // Frame end comes 39 idle bit times after the last stop bit
    task automatic frame(input logic [7:0] a, input logic [7:0] v);
        rxq.delete();
        master.send_byte(a);
        master.send_byte(v);
        for (int i = 0; i < 45 * div && rx_frame_end !== 1'b1; i++) @(posedge clk_sys);
        got_end = (rx_frame_end === 1'b1);
    endtask : frame

    task automatic send_reply(input logic [7:0] v);
        tx_data  <= v;
        tx_valid <= 1'b1;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            if (tx_ready === 1'b1) break;
        end
        tx_valid <= 1'b0;
    endtask : send_reply

    initial begin
        #(100 * 90000);
        bad_count++;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1; clk_en = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = '0; tx_data = 8'h00; tx_valid = 1'b0;
        cfg_wr_req = 1'b0; cfg_wr_reg = 16'h0000;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk_reg(OFS_STATION, 32'h00000001);
        chk_reg(OFS_BAUD, 32'h00000003);
        chk_reg(OFS_CTRL, 32'h00000000);
        chk_reg(OFS_TIMEOUT, 32'h00000000);
        chk_reg(OFS_REPLY, 32'h00000000);
        chk_reg(8'h18, 32'h00000000);
        wr(OFS_STATION, 32'h000000c8);
        chk_reg(OFS_STATION, 32'h00000001);
        wr(OFS_STATION, 32'h000000c7);
        chk_reg(OFS_STATION, 32'h000000c7);
        wr(OFS_TIMEOUT, 32'h00000064);
        chk_reg(OFS_TIMEOUT, 32'h00000000);
        wr(OFS_TIMEOUT, 32'h00000063);
        chk_reg(OFS_TIMEOUT, 32'h00000063);
        wr(OFS_TIMEOUT, 32'h00000000);
        wr(OFS_REPLY, 32'h00000006);
        chk_reg(OFS_REPLY, 32'h00000000);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_BAUD, 32'(c));
            chk_reg(OFS_BAUD, 32'(c));
        end
        div = CLK_HZ / 115200;
        master.div = div;
        gate(16'h0003, 1'b0);
        gate(16'h0004, 1'b1);
        gate(16'h0005, 1'b1);
        wr(OFS_CTRL, 32'h00000001);
        gate(16'h0003, 1'b1);
        wr(OFS_CTRL, 32'h00000000);
        wr(OFS_STATION, 32'h00000005);
        frame(8'h05, 8'ha5);
        check({got_end, 7'h0, rxq[0], rxq[1]}, {8'h80, 8'h05, 8'ha5}, "own frame");
        frame(8'h06, 8'ha5);
        check(32'(rxq.size()), 32'h0, "foreign frame");
        wr(OFS_STATION, 32'h00000000);
        frame(8'hff, 8'h11);
        check({got_end, 7'h0, rxq[0], rxq[1]}, {8'h80, 8'hff, 8'h11}, "address 255");
        repeat (3) @(posedge clk_sys);
        check({31'h0, tx_ready}, 32'h1, "standard reply window");
        // Status: window open, not in frame, transmitter idle, no alert
        chk_reg(OFS_STATUS, 32'h00000004);
        clk_en <= 1'b0;
        @(posedge clk_sys);
        check({31'h0, tx_ready}, 32'h0, "frozen, no reply taken");
        clk_en <= 1'b1;
        fork
            master.get_byte(rb, stop);
            send_reply(8'h3c);
        join
        check({23'h0, stop, rb}, 32'h0000013c, "reply byte");
        wr(OFS_REPLY, 32'h00000001);
        frame(8'hff, 8'h22);
        // Ten characters are 110 bit times; look at nine and then allow two more
        repeat (9 * 11 * div) @(posedge clk_sys);
        check({31'h0, tx_ready}, 32'h0, "reply held back");
        for (int i = 0; i < 2 * 11 * div && tx_ready !== 1'b1; i++) @(posedge clk_sys);
        check({31'h0, tx_ready}, 32'h1, "reply after ten chars");
        wr(OFS_REPLY, 32'h00000000);
        wr(OFS_TIMEOUT, 32'h00000002);
        frame(8'hff, 8'h33);
        repeat (450) @(posedge clk_sys);
        check({31'h0, relay_alert}, 32'h0, "alert within timeout");
        repeat (250) @(posedge clk_sys);
        check({31'h0, relay_alert}, 32'h1, "alert after gap");
        wr(OFS_TIMEOUT, 32'h00000000);
        repeat (3) @(posedge clk_sys);
        check({31'h0, relay_alert}, 32'h0, "supervision off");
        finish_test();
    end
endmodule : tb

bind modbus_serial_slave_link link_props #(.SEC_CYCLES_P(SEC_CYCLES_P)) u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .hreadyout(hreadyout),
    .hresp(hresp), .txd(txd), .tx_drive_en(tx_drive_en), .rx_valid(rx_valid),
    .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .cfg_wr_req(cfg_wr_req), .cfg_wr_reg(cfg_wr_reg), .cfg_wr_allow(cfg_wr_allow),
    .relay_alert(relay_alert));
